// ===== verilog/tfc_cmd_exec.sv
// Command execution for read, verify, no-op, sense and password-disable
// Function
// RULE1: Opcodes 20H and 21H both mean read.
// RULE2: Count zero reads 256, else count sectors.
// RULE3: Read starts at the task-file address.
// RULE4: Per sector: busy, fill, request, unbusy, interrupt.
// RULE5: Host takes 512 bytes per request.
// RULE6: Read done leaves last sector address.
// RULE7: Read error stops, keeps address and data.
// RULE8: Verify opcodes read without data request.
// RULE9: Verify busy until checked, one interrupt.
// RULE10: Verify done leaves last sector address.
// RULE11: Verify error loads address and unverified count.
// RULE12: Opcodes 1XH complete with no effect.
// RULE13: Opcode 03H puts extended code in error.
// RULE14: Codes 00,01,09,20,21,2F as listed.
// RULE15: Codes 11,18,10/14,1F for media faults.
// RULE16: Diagnostic, voltage, spare, format codes pass through.
// RULE17: Opcode F6H takes one host sector.
// RULE18: Word0 bit0 selects; words 1-16 password.
// RULE19: Matching password turns lock mode off.
// RULE20: Stored master password is never changed.
// RULE21: Mismatch keeps lock, ends with abort.
// RULE22: Last host read clears request, stays idle.
`timescale 1ns/1ps
`include "tfc_map.svh"
module tfc_cmd_exec
   import tfc_pkg::*;
#(
   parameter int WORDS = `TFC_SECTOR_WORDS,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host task file
   input wire tfc_hreq_t hreq,
   output logic [15:0] hst_rdata,
   output logic intrq,
   // Media engine
   output logic med_req_valid,
   output tfc_med_req_t med_req,
   input wire logic med_data_valid,
   input wire logic [15:0] med_data,
   output logic med_data_ready,
   input wire tfc_med_end_t med_end,
   // Firmware side
   input wire logic diag_valid,
   input wire logic [7:0] diag_code,
   input wire logic [255:0] pw_user,
   input wire logic [255:0] pw_master,
   input wire logic lock_set,
   output logic lock_mode
);
   localparam int PW = $clog2(WORDS);

   generate
      if (WORDS < `TFC_PW_WORDS + 1 || (WORDS & (WORDS - 1)) != 0) begin : g_chk
         $error("sector words must be a power of two above the password size");
      end
   endgenerate

   tfc_state_t state;
   logic [7:0] cnt;
   logic [7:0] lba0;
   logic [7:0] lba1;
   logic [7:0] lba2;
   logic [7:0] dhs;
   logic [7:0] err_reg;
   logic [7:0] ext_code;
   logic bsy;
   logic drq;
   logic err;
   logic verify;
   logic stop_rd;
   logic [8:0] remaining;
   logic done_seen;
   tfc_med_res_t done_res;
   logic [PW-1:0] ptr;
   logic [15:0] buf_mem [WORDS];
   logic [27:0] lba_next;
   logic fifo_valid;
   logic [15:0] fifo_data;
   logic fifo_pop;
   logic wr_hit;
   logic cmd_wr;
   logic fill_end;
   logic data_rd;
   logic data_wr;
   logic xfer_last;
   logic pw_last;
   logic more;
   logic res_ok;
   logic step_addr;
   logic cnt_err_load;
   logic pw_match;

   // Media words queue here; the queue drains into the buffer only while filling
   tfc_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(med_data_valid),
      .in_data(med_data),
      .in_ready(med_data_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Address of the following sector
   tfc_lba_step #(.AW(28)) u_step (
      .lba_in({dhs[3:0], lba2, lba1, lba0}),
      .lba_out(lba_next),
      .wrap()
   );

   // Compare words 1..16 against the chosen stored password
   function automatic logic pw_equal(input logic [255:0] pw);
      logic eq;
      eq = 1'b1;
      for (int i = 0; i < `TFC_PW_WORDS; i++) begin
         if (buf_mem[i + 1] != pw[i*16 +: 16]) begin
            eq = 1'b0;
         end
      end
      return eq;
   endfunction

   // Decoded events of this cycle
   always_comb begin
      wr_hit = hreq.wr && !bsy;
      cmd_wr = wr_hit && hreq.addr == `TFC_A_CMD && state == ST_IDLE;
      fifo_pop = (state == ST_FILL) && !verify && fifo_valid;
      fill_end = (state == ST_FILL) && done_seen && (verify || !fifo_valid);
      data_rd = hreq.rd && hreq.addr == `TFC_A_DATA && state == ST_XFER;
      data_wr = hreq.wr && hreq.addr == `TFC_A_DATA && state == ST_PWIN;
      xfer_last = data_rd && ptr == PW'(WORDS - 1); // RULE5
      pw_last = data_wr && ptr == PW'(WORDS - 1);
      more = remaining != 9'h001;
      res_ok = !done_res[1];
      step_addr = (xfer_last && more && !stop_rd)
         || (fill_end && verify && res_ok && more); // RULE6 RULE10
      cnt_err_load = fill_end && verify && !res_ok; // RULE11
      pw_match = buf_mem[0][`TFC_PW_SEL_BIT] ? pw_equal(pw_master)
         : pw_equal(pw_user); // RULE18
   end

   // Task-file registers: host writes when idle, stepping and error reload
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= `TFC_RST_CNT;
         lba0 <= 8'h00;
         lba1 <= 8'h00;
         lba2 <= 8'h00;
         dhs <= 8'h00;
      end else if (step_addr) begin
         {dhs[3:0], lba2, lba1, lba0} <= lba_next;
      end else if (cnt_err_load) begin
         cnt <= remaining[7:0]; // RULE11
      end else if (wr_hit && state == ST_IDLE) begin
         unique case (hreq.addr)
            `TFC_A_CNT: cnt <= hreq.wdata[7:0];
            `TFC_A_LBA0: lba0 <= hreq.wdata[7:0];
            `TFC_A_LBA1: lba1 <= hreq.wdata[7:0];
            `TFC_A_LBA2: lba2 <= hreq.wdata[7:0];
            `TFC_A_DHS: dhs <= hreq.wdata[7:0];
            `TFC_A_DATA, `TFC_A_FEAT, `TFC_A_CMD: ;
         endcase
      end
   end

   // Sector buffer and its word pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr <= '0;
      end else if (cmd_wr || state == ST_FETCH) begin
         ptr <= '0;
      end else if (fifo_pop || data_rd || data_wr) begin
         ptr <= ptr + 1'b1;
      end
   end

   // Buffer storage, from media or from the host password sector
   always_ff @(posedge clk) begin
      if (fifo_pop) begin
         buf_mem[ptr] <= fifo_data;
      end else if (data_wr) begin
         buf_mem[ptr] <= hreq.wdata; // RULE17
      end
   end

   // Media completion is caught and held until the next sector fetch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_seen <= 1'b0;
         done_res <= MED_OK;
      end else if (state == ST_FETCH) begin
         done_seen <= 1'b0;
      end else if (med_end.done && state == ST_FILL) begin
         done_seen <= 1'b1;
         done_res <= med_end.res;
      end
   end

   // Media request, issued once per sector
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         med_req_valid <= 1'b0;
         med_req <= '0;
      end else begin
         med_req_valid <= (state == ST_FETCH);
         med_req.lba <= {dhs[3:0], lba2, lba1, lba0}; // RULE3
         med_req.check_only <= verify; // RULE8
      end
   end

   // Lock mode; a set from firmware wins over a clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_mode <= 1'b0;
      end else if (lock_set) begin
         lock_mode <= 1'b1;
      end else if (state == ST_PWCHK && pw_match) begin
         lock_mode <= 1'b0; // RULE19 RULE20
      end
   end

   // Command sequencer with status, error and interrupt
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bsy <= 1'b0;
         drq <= 1'b0;
         err <= 1'b0;
         verify <= 1'b0;
         stop_rd <= 1'b0;
         remaining <= 9'h001;
         err_reg <= `TFC_RST_ERR;
         ext_code <= `TFC_EX_NONE;
         intrq <= 1'b0;
      end else begin
         // A status read acknowledges; a new event below wins
         if (hreq.rd && hreq.addr == `TFC_A_CMD) begin
            intrq <= 1'b0;
         end
         if (diag_valid && !bsy) begin
            ext_code <= diag_code; // RULE16
         end
         unique case (state)
            ST_IDLE: begin
               if (cmd_wr) begin
                  err <= 1'b0;
                  stop_rd <= 1'b0;
                  remaining <= (cnt == 8'h00) ? 9'h100 : {1'b0, cnt}; // RULE2
                  if (hreq.wdata[7:0] == `TFC_OP_RD0
                     || hreq.wdata[7:0] == `TFC_OP_RD1) begin
                     verify <= 1'b0; // RULE1
                     bsy <= 1'b1; // RULE4
                     state <= ST_FETCH;
                  end else if (hreq.wdata[7:0] == `TFC_OP_VF0
                     || hreq.wdata[7:0] == `TFC_OP_VF1) begin
                     verify <= 1'b1; // RULE8
                     bsy <= 1'b1; // RULE9
                     state <= ST_FETCH;
                  end else if (hreq.wdata[7:4] == `TFC_OP_NOP_HI) begin
                     intrq <= 1'b1; // RULE12
                  end else if (hreq.wdata[7:0] == `TFC_OP_SENSE) begin
                     err_reg <= ext_code; // RULE13
                     intrq <= 1'b1;
                  end else if (hreq.wdata[7:0] == `TFC_OP_PWDIS) begin
                     drq <= 1'b1; // RULE17
                     state <= ST_PWIN;
                  end else begin
                     err <= 1'b1;
                     err_reg <= 8'h01 << `TFC_ER_ABRT;
                     ext_code <= `TFC_EX_BAD_CMD; // RULE14
                     intrq <= 1'b1;
                  end
               end
            end
            ST_FETCH: state <= ST_FILL;
            ST_FILL: begin
               if (fill_end) begin
                  unique case (done_res) // RULE15
                     MED_OK: ext_code <= `TFC_EX_NONE;
                     MED_CORR: ext_code <= `TFC_EX_CORR;
                     MED_UNC: ext_code <= `TFC_EX_UNC;
                     MED_IDNF: ext_code <= `TFC_EX_IDNF;
                  endcase
                  if (!res_ok) begin
                     err <= 1'b1;
                     err_reg <= (done_res == MED_UNC) ? 8'h01 << `TFC_ER_UNC
                        : 8'h01 << `TFC_ER_IDNF;
                  end
                  if (verify) begin
                     if (res_ok && more) begin
                        remaining <= remaining - 9'h001;
                        state <= ST_FETCH;
                     end else begin
                        bsy <= 1'b0; // RULE9 RULE11
                        intrq <= 1'b1;
                        state <= ST_IDLE;
                     end
                  end else if (done_res == MED_IDNF) begin
                     bsy <= 1'b0; // RULE7
                     intrq <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     stop_rd <= (done_res == MED_UNC); // RULE7
                     drq <= 1'b1; // RULE4
                     bsy <= 1'b0;
                     intrq <= 1'b1;
                     state <= ST_XFER;
                  end
               end
            end
            ST_XFER: begin
               if (xfer_last) begin
                  drq <= 1'b0;
                  if (more && !stop_rd) begin
                     remaining <= remaining - 9'h001;
                     bsy <= 1'b1; // RULE4
                     state <= ST_FETCH;
                  end else begin
                     state <= ST_IDLE; // RULE22
                  end
               end
            end
            ST_PWIN: begin
               if (pw_last) begin
                  drq <= 1'b0;
                  bsy <= 1'b1;
                  state <= ST_PWCHK;
               end
            end
            ST_PWCHK: begin
               bsy <= 1'b0;
               intrq <= 1'b1;
               state <= ST_IDLE;
               if (!pw_match) begin
                  err <= 1'b1; // RULE21
                  err_reg <= 8'h01 << `TFC_ER_ABRT;
                  ext_code <= `TFC_EX_ABORT;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Host read port: data, error, task file and status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hst_rdata <= 16'h0000;
      end else if (hreq.rd) begin
         unique case (hreq.addr)
            `TFC_A_DATA: hst_rdata <= data_rd ? buf_mem[ptr] : 16'h0000;
            `TFC_A_FEAT: hst_rdata <= {8'h00, err_reg};
            `TFC_A_CNT: hst_rdata <= {8'h00, cnt};
            `TFC_A_LBA0: hst_rdata <= {8'h00, lba0};
            `TFC_A_LBA1: hst_rdata <= {8'h00, lba1};
            `TFC_A_LBA2: hst_rdata <= {8'h00, lba2};
            `TFC_A_DHS: hst_rdata <= {8'h00, dhs};
            `TFC_A_CMD: hst_rdata <= {8'h00, bsy, !bsy, 2'b00, drq, 2'b00, err};
         endcase
      end
   end
endmodule // tfc_cmd_exec

// ===== pkg/tfc_map.svh
// Task-file offsets, field positions, opcodes, codes and reset values
`ifndef TFC_MAP_SVH
`define TFC_MAP_SVH
`define TFC_A_DATA 3'h0
`define TFC_A_FEAT 3'h1
`define TFC_A_CNT 3'h2
`define TFC_A_LBA0 3'h3
`define TFC_A_LBA1 3'h4
`define TFC_A_LBA2 3'h5
`define TFC_A_DHS 3'h6
`define TFC_A_CMD 3'h7
`define TFC_OP_RD0 8'h20
`define TFC_OP_RD1 8'h21
`define TFC_OP_VF0 8'h40
`define TFC_OP_VF1 8'h41
`define TFC_OP_NOP_HI 4'h1
`define TFC_OP_SENSE 8'h03
`define TFC_OP_PWDIS 8'hf6
`define TFC_ST_BSY 7
`define TFC_ST_DRDY 6
`define TFC_ST_DRQ 3
`define TFC_ST_ERR 0
`define TFC_ER_ABRT 2
`define TFC_ER_IDNF 4
`define TFC_ER_UNC 6
`define TFC_EX_NONE 8'h00
`define TFC_EX_SELF_OK 8'h01
`define TFC_EX_MISC 8'h09
`define TFC_EX_BAD_CMD 8'h20
`define TFC_EX_BAD_ADDR 8'h21
`define TFC_EX_ADDR_OVF 8'h2f
`define TFC_EX_UNC 8'h11
`define TFC_EX_CORR 8'h18
`define TFC_EX_IDNF 8'h10
`define TFC_EX_ABORT 8'h1f
`define TFC_RST_CNT 8'h01
`define TFC_RST_ERR 8'h00
`define TFC_SECTOR_WORDS 256
`define TFC_PW_WORDS 16
`define TFC_PW_SEL_BIT 0
`endif

// ===== pkg/tfc_pkg.sv
// Types shared by the task-file command logic
package tfc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_FILL = 3'b010,
      ST_XFER = 3'b011,
      ST_PWIN = 3'b100,
      ST_PWCHK = 3'b101
   } tfc_state_t;
   typedef enum logic [1:0] {
      MED_OK = 2'b00,
      MED_CORR = 2'b01,
      MED_UNC = 2'b10,
      MED_IDNF = 2'b11
   } tfc_med_res_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [15:0] wdata;
   } tfc_hreq_t;
   typedef struct packed {
      logic [27:0] lba;
      logic check_only;
   } tfc_med_req_t;
   typedef struct packed {
      logic done;
      tfc_med_res_t res;
   } tfc_med_end_t;
endpackage

// ===== verilog/tfc_fifo.sv
// Word FIFO between the media stream and the sector buffer
`timescale 1ns/1ps
module tfc_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   generate
      if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
         $error("tfc_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   // Handshakes on both sides
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_idx];

   // Occupancy after this edge
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Pointers, occupancy and registered ready
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_idx <= wr_idx + 1'b1;
         end
         if (pop) begin
            rd_idx <= rd_idx + 1'b1;
         end
         count <= next_count;
         in_ready <= (next_count != D[AW:0]);
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end
endmodule // tfc_fifo

// ===== verilog/tfc_lba_step.sv
// Next sector address, wrapping at the top of the address space
`timescale 1ns/1ps
module tfc_lba_step #(
   parameter int AW = 28
) (
   // Address in and out
   input wire logic [AW-1:0] lba_in,
   output logic [AW-1:0] lba_out,
   output logic wrap
);
   generate
      if (AW < 8) begin : g_chk
         $error("tfc_lba_step needs at least 8 address bits");
      end
   endgenerate

   // Step by one sector
   assign lba_out = lba_in + 1'b1;
   assign wrap = &lba_in;
endmodule // tfc_lba_step

// ===== bench/tfc_cmd_props.sv
// Port checker for the task-file command block
`timescale 1ns/1ps
`include "tfc_map.svh"
module tfc_cmd_props
   import tfc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host, media and lock
   input wire tfc_hreq_t hreq,
   input wire logic intrq,
   input wire logic med_req_valid,
   input wire tfc_med_req_t med_req,
   input wire logic lock_set,
   input wire logic lock_mode
);
   logic [27:0] addr_sh;
   logic cmd_wr;
   logic [7:0] op;
   // Command strobe and opcode
   assign cmd_wr = hreq.wr && hreq.addr == `TFC_A_CMD;
   assign op = hreq.wdata[7:0];
   // Shadow of the start address the host wrote
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_sh <= '0;
      end else if (hreq.wr) begin
         case (hreq.addr)
            `TFC_A_LBA0: addr_sh[7:0] <= hreq.wdata[7:0];
            `TFC_A_LBA1: addr_sh[15:8] <= hreq.wdata[7:0];
            `TFC_A_LBA2: addr_sh[23:16] <= hreq.wdata[7:0];
            `TFC_A_DHS: addr_sh[27:24] <= hreq.wdata[3:0];
            default: addr_sh <= addr_sh;
         endcase
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_fetch: assert property (
      cmd_wr && op inside {8'h20, 8'h21} |-> ##2 med_req_valid && !med_req.check_only)
      else $error("read opcode did not fetch a sector");
   a_verify_fetch: assert property (
      cmd_wr && op inside {8'h40, 8'h41} |-> ##2 med_req_valid && med_req.check_only)
      else $error("verify opcode did not fetch a check");
   a_start_addr: assert property (
      cmd_wr && op inside {8'h20, 8'h21, 8'h40, 8'h41} |-> ##2 med_req.lba == addr_sh)
      else $error("first sector address wrong");
   a_nop_quiet: assert property (
      cmd_wr && op[7:4] == 4'h1 |-> !med_req_valid [*4])
      else $error("no-op touched the media");
   a_nop_irq: assert property (
      cmd_wr && op[7:4] == 4'h1 |-> ##[1:4] intrq)
      else $error("no-op did not complete");
   a_sense_quiet: assert property (
      cmd_wr && op == 8'h03 |-> ##1 !med_req_valid ##1 !med_req_valid)
      else $error("sense touched the media");
   a_irq_clear: assert property (
      $fell(intrq) |-> $past(hreq.rd && hreq.addr == `TFC_A_CMD))
      else $error("interrupt dropped without status read");
   a_lock_set: assert property (lock_set |=> lock_mode)
      else $error("lock mode not set");
   a_unlock_cause: assert property (
      $fell(lock_mode) |-> $past(hreq.wr && hreq.addr == `TFC_A_DATA, 2))
      else $error("lock left without password sector");
   c_verify: cover property (med_req_valid && med_req.check_only);
   c_read: cover property (med_req_valid && !med_req.check_only);
   c_unlock: cover property ($fell(lock_mode));
endmodule // tfc_cmd_props
bind tfc_cmd_exec tfc_cmd_props chk_u (.clk(clk), .rst_n(rst_n), .hreq(hreq), .intrq(intrq),
   .med_req_valid(med_req_valid), .med_req(med_req), .lock_set(lock_set), .lock_mode(lock_mode));

// ===== bench/tfc_media_model.sv
// Behavioural media engine answering sector requests
`timescale 1ns/1ps
module tfc_media_model
   import tfc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requests from the block
   input wire logic req_valid,
   input wire tfc_med_req_t req,
   // Word stream and sector end
   output logic data_valid,
   output logic [15:0] data,
   input wire logic data_ready,
   output tfc_med_end_t med_end,
   // Test controls
   input wire logic slow,
   input wire logic [8:0] fail_at,
   input wire tfc_med_res_t fail_res,
   output logic [8:0] n_req
);
   logic busy;
   logic words;
   logic hit;
   logic [8:0] idx;
   logic [7:0] tag;
   tfc_med_res_t res;
   // Chosen request gets the injected fault
   assign hit = n_req + 9'h001 == fail_at;
   // One sector per request; a released data line shows the inverse value
   always_ff @(posedge clk) begin
      med_end <= '0;
      if (!rst_n) begin
         busy <= 1'b0;
         data_valid <= 1'b0;
         data <= '0;
         n_req <= '0;
      end else if (req_valid) begin
         busy <= 1'b1;
         idx <= '0;
         tag <= req.lba[7:0];
         n_req <= n_req + 9'h001;
         res <= hit ? fail_res : MED_OK;
         words <= !req.check_only && !(hit && fail_res == MED_IDNF);
      end else if (busy && words && idx != 9'h100) begin
         if (data_valid && data_ready) begin
            idx <= idx + 9'h001;
            data_valid <= !slow && idx != 9'h0ff;
            data <= (!slow && idx != 9'h0ff) ? {tag, idx[7:0] + 8'h01} : ~data;
         end else if (!data_valid) begin
            data_valid <= 1'b1;
            data <= {tag, idx[7:0]};
         end
      end else if (busy) begin
         busy <= 1'b0;
         med_end <= '{done: 1'b1, res: res};
      end
   end
endmodule // tfc_media_model

// ===== bench/tfc_cmd_exec_tb.sv
// Self-checking bench for the task-file command block
`timescale 1ns/1ps
`include "tfc_map.svh"
module tfc_cmd_exec_tb
   import tfc_pkg::*;
();
   logic clk;
   logic rst_n;
   tfc_hreq_t hreq;
   logic [15:0] hst_rdata;
   logic intrq, med_req_valid, md_valid, md_ready, diag_valid, lock_set, lock_mode, slow;
   tfc_med_req_t med_req;
   logic [15:0] md;
   logic [15:0] q;
   tfc_med_end_t med_end;
   logic [7:0] diag_code;
   logic [255:0] pw_user, pw_master;
   logic [8:0] fail_at, n_req, b;
   tfc_med_res_t fail_res;
   int n_errors = 0;
   int n_compared = 0;
   // Block under test and its media engine
   tfc_cmd_exec dut_u (.clk(clk), .rst_n(rst_n), .hreq(hreq), .hst_rdata(hst_rdata),
      .intrq(intrq), .med_req_valid(med_req_valid), .med_req(med_req), .med_data_valid(md_valid),
      .med_data(md), .med_data_ready(md_ready), .med_end(med_end), .diag_valid(diag_valid),
      .diag_code(diag_code), .pw_user(pw_user), .pw_master(pw_master), .lock_set(lock_set),
      .lock_mode(lock_mode));
   tfc_media_model media_u (.clk(clk), .rst_n(rst_n), .req_valid(med_req_valid), .req(med_req),
      .data_valid(md_valid), .data(md), .data_ready(md_ready), .med_end(med_end), .slow(slow),
      .fail_at(fail_at), .fail_res(fail_res), .n_req(n_req));
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic wrap_up();
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // One host access, strobe for one edge, then a quiet cycle
   task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
      hreq = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      hreq = '0;
      q = hst_rdata;
      @(negedge clk);
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string m);
      bus(1'b0, a, 16'h0000);
      chk({8'h00, q[7:0]}, {8'h00, e}, m);
   endtask
   task automatic wait_irq();
      for (int i = 0; i < 6000 && intrq !== 1'b1; i++) @(negedge clk);
      chk({15'h0000, intrq}, 16'h0001, "interrupt");
   endtask
   task automatic issue(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] lo);
      b = n_req;
      bus(1'b1, `TFC_A_CNT, {8'h00, cnt});
      bus(1'b1, `TFC_A_LBA0, {8'h00, lo});
      bus(1'b1, `TFC_A_LBA1, 16'h0000);
      bus(1'b1, `TFC_A_LBA2, 16'h0000);
      bus(1'b1, `TFC_A_DHS, 16'h00e0);
      bus(1'b1, `TFC_A_CMD, {8'h00, op});
   endtask
   task automatic sector(input logic [7:0] lo, input logic [7:0] st);
      wait_irq();
      rchk(`TFC_A_CMD, st, "sector status");
      for (int i = 0; i < 256; i++) begin
         bus(1'b0, `TFC_A_DATA, 16'h0000);
         chk(q, {lo, i[7:0]}, "sector word");
      end
   endtask
   task automatic sense(input logic [7:0] e);
      bus(1'b1, `TFC_A_CMD, 16'h0003);
      wait_irq();
      rchk(`TFC_A_CMD, 8'h40, "sense status");
      rchk(`TFC_A_FEAT, e, "extended code");
   endtask
   task automatic pw(input logic sel, input logic [15:0] base);
      logic [15:0] w;
      bus(1'b1, `TFC_A_CMD, 16'h00f6);
      rchk(`TFC_A_CMD, 8'h48, "sector request");
      for (int i = 0; i < 256; i++) begin
         w = (i == 0) ? {15'h0000, sel} : ((i <= 16) ? base + 16'(i) : 16'h0000);
         bus(1'b1, `TFC_A_DATA, w);
      end
      wait_irq();
   endtask
   task automatic lock_pulse();
      lock_set = 1'b1;
      @(negedge clk);
      lock_set = 1'b0;
      chk({15'h0000, lock_mode}, 16'h0001, "locked");
   endtask
   task automatic t_read();
      slow = 1'b1;
      issue(8'h21, 8'h02, 8'h10);
      sector(8'h10, 8'h48);
      sector(8'h11, 8'h48);
      rchk(`TFC_A_CMD, 8'h40, "read done");
      rchk(`TFC_A_LBA0, 8'h11, "last address");
      chk({7'h00, n_req - b}, 16'h0002, "sectors fetched");
      sense(8'h18);
      slow = 1'b0;
      fail_at = n_req + 9'h002;
      fail_res = MED_UNC;
      issue(8'h20, 8'h03, 8'h40);
      sector(8'h40, 8'h48);
      sector(8'h41, 8'h49);
      rchk(`TFC_A_CMD, 8'h41, "read stopped");
      rchk(`TFC_A_LBA0, 8'h41, "fault address");
      sense(8'h11);
   endtask
   task automatic t_verify();
      fail_at = '0;
      issue(8'h40, 8'h00, 8'h05);
      wait_irq();
      rchk(`TFC_A_CMD, 8'h40, "verify done");
      chk({7'h00, n_req - b}, 16'h0100, "zero count");
      rchk(`TFC_A_LBA0, 8'h04, "last verified");
      rchk(`TFC_A_LBA1, 8'h01, "address carry");
      fail_at = n_req + 9'h003;
      fail_res = MED_IDNF;
      issue(8'h41, 8'h05, 8'h20);
      wait_irq();
      rchk(`TFC_A_CMD, 8'h41, "verify stopped");
      rchk(`TFC_A_LBA0, 8'h22, "fault address");
      rchk(`TFC_A_CNT, 8'h03, "sectors left");
      sense(8'h10);
   endtask
   task automatic t_codes();
      b = n_req;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, `TFC_A_CMD, (i == 0) ? 16'h0010 : 16'h001f);
         wait_irq();
         rchk(`TFC_A_CMD, 8'h40, "no-op status");
      end
      chk({7'h00, n_req - b}, 16'h0000, "no-op fetch");
      sense(8'h10);
      bus(1'b1, `TFC_A_CMD, 16'h0099);
      wait_irq();
      rchk(`TFC_A_CMD, 8'h41, "invalid status");
      sense(8'h20);
      diag_code = 8'h3a;
      diag_valid = 1'b1;
      @(negedge clk);
      diag_valid = 1'b0;
      sense(8'h3a);
   endtask
   task automatic t_password();
      lock_pulse();
      pw(1'b1, 16'h1100);
      rchk(`TFC_A_CMD, 8'h41, "mismatch");
      rchk(`TFC_A_FEAT, 8'h04, "abort bit");
      chk({15'h0000, lock_mode}, 16'h0001, "still locked");
      sense(8'h1f);
      pw(1'b0, 16'h1100);
      rchk(`TFC_A_CMD, 8'h40, "user match");
      chk({15'h0000, lock_mode}, 16'h0000, "unlocked");
      lock_pulse();
      pw(1'b1, 16'h2200);
      chk({15'h0000, lock_mode}, 16'h0000, "master unlock");
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      hreq = '0;
      diag_valid = 1'b0;
      diag_code = '0;
      lock_set = 1'b0;
      slow = 1'b0;
      fail_at = 9'h002;
      fail_res = MED_CORR;
      for (int i = 1; i <= 16; i++) begin
         pw_user[(i - 1) * 16 +: 16] = 16'h1100 + 16'(i);
         pw_master[(i - 1) * 16 +: 16] = 16'h2200 + 16'(i);
      end
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      rchk(`TFC_A_CNT, 8'h01, "count reset");
      t_read();
      t_verify();
      t_codes();
      t_password();
      wrap_up();
   end
   // Watchdog
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule // tfc_cmd_exec_tb
